// ---- common/srtbd_defs.vh ----
// Constants for the 11-bit texel block decoder
`ifndef SRTBD_DEFS_VH
`define SRTBD_DEFS_VH
// Format select codes
`define SRTBD_FMT_U1       2'h0
`define SRTBD_FMT_S1       2'h1
`define SRTBD_FMT_U2       2'h2
// Bytes per block
`define SRTBD_BYTES_64     5'h08
`define SRTBD_BYTES_128    5'h10
// Field positions inside a 64-bit channel word
`define SRTBD_BASE_HI      63
`define SRTBD_BASE_LO      56
`define SRTBD_MULT_HI      55
`define SRTBD_MULT_LO      52
`define SRTBD_TBL_HI       51
`define SRTBD_TBL_LO       48
`define SRTBD_IDX_HI       47
// Datapath constants
`define SRTBD_BASE_BAD     8'h80
`define SRTBD_BASE_SUB     8'h81
`define SRTBD_UNS_OFS      3'h4
`define SRTBD_UMAX         14'h07FF
`define SRTBD_SMAX         14'h03FF
`define SRTBD_SMIN         14'h3C01
// Pixel counter end values
`define SRTBD_LAST_ONE     5'h0F
`define SRTBD_LAST_TWO     5'h1F
// FIFO shape
`define SRTBD_FIFO_DEPTH   32
`define SRTBD_FIFO_AW      5
`define SRTBD_FIFO_WIDTH   33
`endif

// ---- rtl/srtbd_top.v ----
// Texel block decoder: byte assembly, per-pixel decode, output FIFO
// Contract
// R1 - Dual unsigned block is sixteen bytes, red first
// R2 - Red word first eight bytes, green last eight
// R3 - Both channel words use single unsigned decode
// R4 - Unsigned value base*8+4+term, clamped 0..2047
// R5 - Unsigned widening: x<<5 plus x>>6
// R6 - Signed block is eight bytes, big-endian word
// R7 - Upper 16 bits header, lower 48 indices
// R8 - Signed base, -128 treated as -127
// R9 - Signed base shifted left three, no offset
// R10 - Bits 51..48 pick one of sixteen tables
// R11 - Table 13 is -1,-2,-3,-10,0,1,2,9
// R12 - Pixel indices in bits 47..0, pixel b 44..42
// R13 - Nonzero multiplier: modifier*multiplier shifted three
// R14 - Zero multiplier uses modifier unscaled
// R15 - Signed sum clamped to -1023..1023
// R16 - Signed output is 11-bit two's complement
// R17 - Non-negative signed widening: x<<5 plus x>>5
// R18 - Negative signed: negate, replicate, negate back
// R19 - Widened output keeps full 11-bit precision
// R20 - One datapath shared by signed and unsigned
// R21 - Other tables held in fixed ROM
// R22 - Block in with strobes, pixels out fixed latency; code handshakes on both sides, latency follows TEXEL_READY
`timescale 1ns/100ps
`include "srtbd_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Output FIFO with registered head
module srtbd_fifo #(
  parameter WIDTH = `SRTBD_FIFO_WIDTH,
  parameter DEPTH = `SRTBD_FIFO_DEPTH,
  parameter AW    = `SRTBD_FIFO_AW
) (
  // Clock and reset
  input  wire             clk,
  input  wire             srst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output reg              out_valid_ff,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_ff
);
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;
  // Back-pressure and head refill
  assign in_ready = (count_ff != FULL_CNT);
  assign push     = in_valid && in_ready;
  assign pop      = (count_ff != {(AW+1){1'b0}}) && (!out_valid_ff || out_ready);
  // Storage array write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
  // Pointers, level and head register
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff    <= {AW{1'b0}};
      rd_ptr_ff    <= {AW{1'b0}};
      count_ff     <= {(AW+1){1'b0}};
      out_valid_ff <= 1'b0;
      out_data_ff  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff   <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
        out_data_ff <= mem[rd_ptr_ff];
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule // srtbd_fifo

////////////////////////////////////////////////////////////////////////////////
// Decoder top
module srtbd_top #(
  parameter FIFO_DEPTH = `SRTBD_FIFO_DEPTH,
  parameter FIFO_AW    = `SRTBD_FIFO_AW
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        SRST,
  // Block byte input from fetch
  input  wire        BYTE_VALID,
  output wire        BYTE_READY,
  input  wire [7:0]  BYTE_DATA,
  input  wire [1:0]  FORMAT,
  // Decoded texel output to filter
  output wire        TEXEL_VALID,
  input  wire        TEXEL_READY,
  output wire [10:0] TEXEL_VALUE,
  output wire [15:0] TEXEL_WIDE,
  output wire [3:0]  TEXEL_PIXEL,
  output wire        TEXEL_CHANNEL,
  output wire        TEXEL_LAST
);
  localparam [1:0] ST_COLLECT = 2'h1;
  localparam [1:0] ST_DECODE  = 2'h2;
  reg  [1:0]   state_ff;
  reg  [1:0]   nxt_state;
  reg  [127:0] blk_ff;
  reg  [4:0]   nbyte_ff;
  reg  [1:0]   fmt_ff;
  reg  [4:0]   cnt_ff;
  reg          ready_ff;
  wire         take;
  wire         fifo_ready;
  wire         push;
  wire         dual;
  wire         signed_fmt;
  wire [4:0]   need_bytes;
  wire [4:0]   last_cnt;
  wire [63:0]  word;
  wire [47:0]  idx_vec;
  wire [2:0]   pix_idx;
  wire [7:0]   base;
  wire [3:0]   mult;
  wire [3:0]   tbl;
  wire [31:0]  row;
  wire [3:0]   mag;
  wire [32:0]  fifo_in;
  wire [32:0]  fifo_out;
  reg  [7:0]   base_fix;
  reg  signed [13:0] base_s;
  reg  signed [13:0] mod_s;
  reg  signed [13:0] prod_s;
  reg  signed [13:0] term_s;
  reg  signed [13:0] sum_s;
  reg  signed [13:0] clip_s;
  reg  [10:0]  val11;
  reg  [10:0]  mag11;
  reg  [15:0]  rep16;
  reg  [15:0]  wide16;
  // Fixed modifier ROM, four negative then four positive magnitudes
  function [31:0] mod_row;
    input [3:0] t;
    begin
      case (t)
        4'h0:    mod_row = 32'h369F258E;
        4'h1:    mod_row = 32'h37AD269C;
        4'h2:    mod_row = 32'h258D147C;
        4'h3:    mod_row = 32'h246D135C;
        4'h4:    mod_row = 32'h368C257B;
        4'h5:    mod_row = 32'h379B268A;
        4'h6:    mod_row = 32'h478B367A;
        4'h7:    mod_row = 32'h358B247A;
        4'h8:    mod_row = 32'h268A1579;
        4'h9:    mod_row = 32'h258A1479;
        4'hA:    mod_row = 32'h248A1379;
        4'hB:    mod_row = 32'h257A1469;
        4'hC:    mod_row = 32'h347A2369;
        4'hD:    mod_row = 32'h123A0129; // R11
        4'hE:    mod_row = 32'h46893578;
        default: mod_row = 32'h35792468;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Block assembly
  assign take       = BYTE_VALID && ready_ff;
  assign BYTE_READY = ready_ff;
  assign dual       = (fmt_ff == `SRTBD_FMT_U2);
  assign signed_fmt = (fmt_ff == `SRTBD_FMT_S1);
  // Block size follows format seen with the first byte
  assign need_bytes = (((nbyte_ff == 5'h00) ? FORMAT : fmt_ff) == `SRTBD_FMT_U2) ?
                      `SRTBD_BYTES_128 : `SRTBD_BYTES_64; // R1 R6
  assign last_cnt   = dual ? `SRTBD_LAST_TWO : `SRTBD_LAST_ONE;

  // State sequencing
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_COLLECT: begin
        if (take && (nbyte_ff + 5'h01 == need_bytes)) begin
          nxt_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (push && (cnt_ff == last_cnt)) begin
          nxt_state = ST_COLLECT;
        end
      end
      default: nxt_state = ST_COLLECT;
    endcase
  end

  // Byte shift register, counters and format capture
  always @(posedge CLOCK) begin
    if (SRST) begin
      state_ff <= ST_COLLECT;
      blk_ff   <= 128'h0;
      nbyte_ff <= 5'h00;
      fmt_ff   <= `SRTBD_FMT_U1;
      cnt_ff   <= 5'h00;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == ST_COLLECT);
      if (take) begin
        blk_ff <= {blk_ff[119:0], BYTE_DATA}; // R2 R6
        if (nbyte_ff == 5'h00) begin
          fmt_ff <= FORMAT;
        end
        if (nbyte_ff + 5'h01 == need_bytes) begin
          nbyte_ff <= 5'h00;
        end else begin
          nbyte_ff <= nbyte_ff + 5'h01;
        end
      end
      if (push) begin
        if (cnt_ff == last_cnt) begin
          cnt_ff <= 5'h00;
        end else begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction
  // Red from the first eight bytes, green from the last eight
  assign word = (dual && !cnt_ff[4]) ? blk_ff[127:64] : blk_ff[63:0]; // R2 R3
  assign base = word[`SRTBD_BASE_HI:`SRTBD_BASE_LO]; // R7
  assign mult = word[`SRTBD_MULT_HI:`SRTBD_MULT_LO];
  assign tbl  = word[`SRTBD_TBL_HI:`SRTBD_TBL_LO]; // R10
  assign row  = mod_row(tbl); // R21

  // Per-pixel index slots, pixel 0 at the top of the index field
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_idx
      assign idx_vec[3*g+2:3*g] = word[`SRTBD_IDX_HI-3*g:`SRTBD_IDX_HI-3*g-2]; // R12
    end
  endgenerate
  assign pix_idx = idx_vec[{cnt_ff[3:0], 1'b0} + {2'h0, cnt_ff[3:0]} +: 3];
  assign mag     = row[31 - {pix_idx, 2'h0} -: 4]; // R11

  ////////////////////////////////////////////////////////////////////////////
  // Shared arithmetic for both signed and unsigned
  always @* begin
    base_fix = (base == `SRTBD_BASE_BAD) ? `SRTBD_BASE_SUB : base; // R8
    if (signed_fmt) begin
      base_s = {{3{base_fix[7]}}, base_fix, 3'h0}; // R9
    end else begin
      base_s = {3'h0, base, `SRTBD_UNS_OFS}; // R4 R20
    end
    if (pix_idx[2]) begin
      mod_s = {10'h000, mag};
    end else begin
      mod_s = 14'h0000 - {10'h000, mag};
    end
    prod_s = mod_s * $signed({10'h000, mult});
    if (mult != 4'h0) begin
      term_s = prod_s <<< 3; // R13
    end else begin
      term_s = mod_s; // R14
    end
    sum_s = base_s + term_s;
    // Clamp limits differ per format
    if (signed_fmt) begin
      if (sum_s > $signed(`SRTBD_SMAX)) begin
        clip_s = `SRTBD_SMAX; // R15
      end else if (sum_s < $signed(`SRTBD_SMIN)) begin
        clip_s = `SRTBD_SMIN; // R15
      end else begin
        clip_s = sum_s;
      end
    end else begin
      if (sum_s < $signed(14'h0000)) begin
        clip_s = 14'h0000; // R4
      end else if (sum_s > $signed(`SRTBD_UMAX)) begin
        clip_s = `SRTBD_UMAX; // R4
      end else begin
        clip_s = sum_s;
      end
    end
    val11 = clip_s[10:0]; // R16
    // Widening by bit replication
    mag11 = val11[10] ? (11'h000 - val11) : val11;
    rep16 = {mag11, 5'h00} + {10'h000, mag11[10:5]}; // R17
    if (!signed_fmt) begin
      wide16 = {val11, 5'h00} + {11'h000, val11[10:6]}; // R5 R19
    end else if (val11[10]) begin
      wide16 = 16'h0000 - rep16; // R18
    end else begin
      wide16 = rep16; // R17 R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output FIFO, stalls decode when full
  assign push    = (state_ff == ST_DECODE) && fifo_ready; // R22
  assign fifo_in = {cnt_ff[4], cnt_ff[3:0], (cnt_ff == last_cnt), val11, wide16};
  srtbd_fifo #(
    .WIDTH (`SRTBD_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk          (CLOCK),
    .srst         (SRST),
    .in_valid     (push),
    .in_ready     (fifo_ready),
    .in_data      (fifo_in),
    .out_valid_ff (TEXEL_VALID),
    .out_ready    (TEXEL_READY),
    .out_data_ff  (fifo_out)
  );

  // Output fields straight from the FIFO head register
  assign TEXEL_CHANNEL = fifo_out[32];
  assign TEXEL_PIXEL   = fifo_out[31:28];
  assign TEXEL_LAST    = fifo_out[27];
  assign TEXEL_VALUE   = fifo_out[26:16];
  assign TEXEL_WIDE    = fifo_out[15:0];
endmodule // srtbd_top

// ---- verification/srtbd_properties.sv ----
// Concurrent checks on the ports of the texel block decoder
`timescale 1ns/100ps
module srtbd_props #(
  parameter FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SRST,
  // Byte side
  input wire logic        BYTE_VALID,
  input wire logic        BYTE_READY,
  input wire logic [7:0]  BYTE_DATA,
  input wire logic [1:0]  FORMAT,
  // Texel side
  input wire logic        TEXEL_VALID,
  input wire logic        TEXEL_READY,
  input wire logic [10:0] TEXEL_VALUE,
  input wire logic [15:0] TEXEL_WIDE,
  input wire logic [3:0]  TEXEL_PIXEL,
  input wire logic        TEXEL_CHANNEL,
  input wire logic        TEXEL_LAST
);
  logic [4:0] cnt_ff;
  logic [1:0] fmt_ff;
  logic [3:0] pix_ff;
  logic       chan_ff;
  logic       seen_ff;
  // Block length follows the format taken with the first byte
  wire [1:0]  fmt_now  = (cnt_ff == 5'h00) ? FORMAT : fmt_ff;
  wire [4:0]  last_cnt = (fmt_now == 2'h2) ? 5'h0F : 5'h07;
  wire        tk = TEXEL_VALID & TEXEL_READY;
  // Both widening forms of the current value
  wire [15:0] uw = {TEXEL_VALUE, 5'h00} + {11'h000, TEXEL_VALUE[10:6]};
  wire [10:0] mg = TEXEL_VALUE[10] ? -TEXEL_VALUE : TEXEL_VALUE;
  wire [15:0] sm = {mg, 5'h00} + {10'h000, mg[10:5]};
  wire [15:0] sw = TEXEL_VALUE[10] ? -sm : sm;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte count and last taken texel
  always @(posedge CLOCK) begin
    if (SRST) begin
      cnt_ff  <= 5'h00;
      fmt_ff  <= 2'h0;
      pix_ff  <= 4'h0;
      chan_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      if (BYTE_VALID && BYTE_READY) begin
        fmt_ff <= fmt_now;
        cnt_ff <= (cnt_ff == last_cnt) ? 5'h00 : cnt_ff + 5'h01;
      end
      if (tk) begin
        pix_ff  <= TEXEL_PIXEL;
        chan_ff <= TEXEL_CHANNEL;
        seen_ff <= ~TEXEL_LAST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_reset_quiet: assert property ($fell(SRST) |-> !BYTE_READY && !TEXEL_VALID)
    else $error("outputs busy after reset");
  a_texel_hold: assert property (TEXEL_VALID && !TEXEL_READY |=> TEXEL_VALID
    && $stable(TEXEL_VALUE) && $stable(TEXEL_PIXEL)) else $error("texel dropped");
  a_wide_match: assert property (TEXEL_VALID |-> TEXEL_WIDE == uw || TEXEL_WIDE == sw)
    else $error("wide value not replicated");
  a_pixel_order: assert property (tk && seen_ff |-> TEXEL_PIXEL == pix_ff + 4'h1)
    else $error("pixel out of order");
  a_last_pixel: assert property (tk && TEXEL_LAST |-> TEXEL_PIXEL == 4'hF)
    else $error("last flag off pixel 15");
  a_channel_order: assert property (tk && seen_ff |->
    TEXEL_CHANNEL == (chan_ff | (pix_ff == 4'hF))) else $error("channel order");
  a_block_end: assert property (BYTE_VALID && BYTE_READY && cnt_ff == last_cnt
    |=> !BYTE_READY) else $error("ready after block end");
  a_first_texel: assert property ($fell(BYTE_READY) |-> ##[0:4] TEXEL_VALID)
    else $error("no texel after block");
  c_dual: cover property (tk && TEXEL_CHANNEL && TEXEL_LAST);
  c_stall: cover property (TEXEL_VALID && !TEXEL_READY ##1 tk);
  c_full: cover property ((!BYTE_READY && !TEXEL_READY)[*8]);
endmodule // srtbd_props

// ---- verification/srtbd_far_model.sv ----
// Fetch byte source and filter sink around the decoder
`timescale 1ns/100ps
module srtbd_far_model (
  // Clock and control from the bench
  input wire logic         clk,
  input wire logic         go,
  input wire logic [127:0] blk,
  input wire logic [4:0]   nb,
  input wire logic [1:0]   stall,
  // Byte side
  input wire logic         byte_ready,
  output logic             byte_valid,
  output logic [7:0]       byte_data,
  output logic             done,
  // Texel side
  output logic             texel_ready
);
  logic [127:0] sh_ff;
  logic [4:0]   left_ff;
  logic         ph_ff;
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    done       = 1'b0;
    ph_ff      = 1'b0;
  end
  // Bytes leave top first and stand until taken
  always @(posedge clk) begin
    ph_ff <= ~ph_ff;
    if (go) begin
      sh_ff      <= blk << 8;
      left_ff    <= nb;
      byte_valid <= 1'b1;
      byte_data  <= blk[127:120];
      done       <= 1'b0;
    end else if (byte_valid && byte_ready) begin
      left_ff <= left_ff - 5'h01;
      if (left_ff == 5'h01) begin
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
        done       <= 1'b1;
      end else begin
        byte_data <= sh_ff[127:120];
        sh_ff     <= sh_ff << 8;
      end
    end
  end
  // Sink takes always, every other cycle, or never
  assign texel_ready = (stall == 2'h0) | ((stall == 2'h1) & ph_ff);
endmodule // srtbd_far_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the texel block decoder
`timescale 1ns/100ps
module tb_top;
  logic CLOCK = 0, SRST = 1, go = 0;
  logic [1:0] FORMAT = 2'h0, stall = 2'h0;
  logic [127:0] blk = 0;
  logic [4:0] nb = 0;
  wire BYTE_VALID, BYTE_READY, TEXEL_VALID, TEXEL_READY, TEXEL_CHANNEL, TEXEL_LAST, done;
  wire [7:0] BYTE_DATA;
  wire [10:0] TEXEL_VALUE;
  wire [15:0] TEXEL_WIDE;
  wire [3:0] TEXEL_PIXEL;
  int fail_count = 0, compares = 0, cyc = 0;
  int t13[8] = '{-1, -2, -3, -10, 0, 1, 2, 9};
  int t15[8] = '{-3, -5, -7, -9, 2, 4, 6, 8};
  localparam logic [47:0] IA = 48'h053977053977, IB = 48'hFAC688FAC688;

  srtbd_top #(.FIFO_DEPTH(32), .FIFO_AW(5)) dut_u (.CLOCK(CLOCK), .SRST(SRST),
    .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY), .BYTE_DATA(BYTE_DATA), .FORMAT(FORMAT),
    .TEXEL_VALID(TEXEL_VALID), .TEXEL_READY(TEXEL_READY), .TEXEL_VALUE(TEXEL_VALUE),
    .TEXEL_WIDE(TEXEL_WIDE), .TEXEL_PIXEL(TEXEL_PIXEL), .TEXEL_CHANNEL(TEXEL_CHANNEL),
    .TEXEL_LAST(TEXEL_LAST));
  srtbd_far_model far_u (.clk(CLOCK), .go(go), .blk(blk), .nb(nb), .stall(stall),
    .byte_ready(BYTE_READY), .byte_valid(BYTE_VALID), .byte_data(BYTE_DATA), .done(done),
    .texel_ready(TEXEL_READY));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] ev(input logic sg, input logic [63:0] w, input int p);
    int b, m, md, v;
    logic [2:0] ix;
    if (sg) b = $signed(w[63:56]);
    else b = w[63:56];
    if (sg && b == -128) b = -127;
    ix = w[47 - 3 * p -: 3];
    md = (w[51:48] == 4'hD) ? t13[ix] : t15[ix];
    m = w[55:52];
    v = b * 8 + (sg ? 0 : 4) + ((m != 0) ? md * m * 8 : md);
    if (sg) v = (v > 1023) ? 1023 : ((v < -1023) ? -1023 : v);
    else v = (v > 2047) ? 2047 : ((v < 0) ? 0 : v);
    return v[10:0];
  endfunction
  function automatic logic [15:0] ew(input logic sg, input logic [10:0] x);
    int a;
    if (!sg) return {x, 5'h00} + {11'h000, x[10:6]};
    a = $signed(x);
    a = (a < 0) ? -a : a;
    a = (a << 5) + (a >> 5);
    if (x[10]) a = -a;
    return a[15:0];
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  task automatic send(input logic [1:0] f, input logic [63:0] w0, w1);
    int c;
    FORMAT = f;
    blk = {w0, w1};
    nb = (f == 2'h2) ? 5'h10 : 5'h08;
    go = 1'b1;
    @(posedge CLOCK);
    #2 go = 1'b0;
    c = 0;
    while (done !== 1'b1 && c < 300) begin
      @(posedge CLOCK);
      #2 c++;
    end
    if (done !== 1'b1) check("bytes taken", done, 1);
  endtask
  task automatic collect(input logic [1:0] f, input logic [63:0] w0, w1);
    int k, c, n;
    logic [63:0] w;
    n = (f == 2'h2) ? 32 : 16;
    k = 0;
    c = 0;
    while (k < n && c < 400) begin
      @(negedge CLOCK);
      c++;
      if (TEXEL_VALID === 1'b1 && TEXEL_READY === 1'b1) begin
        w = (k < 16) ? w0 : w1;
        check("value", TEXEL_VALUE, ev(f == 2'h1, w, k % 16));
        check("wide", TEXEL_WIDE, ew(f == 2'h1, ev(f == 2'h1, w, k % 16)));
        check("pixel", TEXEL_PIXEL, k % 16);
        check("channel", TEXEL_CHANNEL, k / 16);
        check("last", TEXEL_LAST, k == n - 1);
        k++;
      end
    end
    if (k < n) check("texel count", k, n);
    // Hand back just after a rising edge so the next stimulus keeps its offset
    @(posedge CLOCK);
    #2;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task sc_unsigned;
    fork
      begin
        send(2'h0, {8'h67, 4'h2, 4'hD, IA}, 0);
        send(2'h3, {8'hFF, 4'hF, 4'hF, IB}, 0);
        send(2'h0, {8'h00, 4'h0, 4'hD, IA}, 0);
      end
      begin
        collect(2'h0, {8'h67, 4'h2, 4'hD, IA}, 0);
        collect(2'h3, {8'hFF, 4'hF, 4'hF, IB}, 0);
        collect(2'h0, {8'h00, 4'h0, 4'hD, IA}, 0);
      end
    join
  endtask
  task sc_signed;
    fork
      begin
        send(2'h1, {8'h3C, 4'h2, 4'hD, IA}, 0);
        send(2'h1, {8'h80, 4'hF, 4'hF, IB}, 0);
        send(2'h1, {8'h41, 4'h0, 4'hD, IB}, 0);
      end
      begin
        collect(2'h1, {8'h3C, 4'h2, 4'hD, IA}, 0);
        collect(2'h1, {8'h80, 4'hF, 4'hF, IB}, 0);
        collect(2'h1, {8'h41, 4'h0, 4'hD, IB}, 0);
      end
    join
  endtask
  task sc_dual;
    stall = 2'h1;
    fork
      send(2'h2, {8'h67, 4'h0, 4'hD, IA}, {8'hF0, 4'h3, 4'hF, IB});
      collect(2'h2, {8'h67, 4'h0, 4'hD, IA}, {8'hF0, 4'h3, 4'hF, IB});
    join
    stall = 2'h0;
  endtask
  task sc_fill;
    stall = 2'h2;
    repeat (3) send(2'h1, {8'h7F, 4'h1, 4'hF, IA}, 0);
    repeat (20) @(posedge CLOCK);
    #2 check("refused", BYTE_READY, 0);
    check("held", TEXEL_VALID, 1);
    stall = 2'h0;
    repeat (3) collect(2'h1, {8'h7F, 4'h1, 4'hF, IA}, 0);
  endtask
  // Reset in mid-decode, then a clean block must follow from pixel 0
  task sc_reset;
    stall = 2'h2;
    send(2'h1, {8'h3C, 4'h2, 4'hD, IA}, 0);
    repeat (4) @(posedge CLOCK);
    #2 check("valid pre-reset", TEXEL_VALID, 1);
    SRST = 1'b1;
    repeat (2) @(posedge CLOCK);
    #2 SRST = 1'b0;
    check("reset valid", TEXEL_VALID, 0);
    check("reset value", TEXEL_VALUE, 0);
    check("reset wide", TEXEL_WIDE, 0);
    check("reset ready", BYTE_READY, 0);
    @(posedge CLOCK);
    #2 check("ready after reset", BYTE_READY, 1);
    stall = 2'h0;
    fork
      send(2'h0, {8'hF0, 4'h3, 4'hF, IB}, 0);
      collect(2'h0, {8'hF0, 4'h3, 4'hF, IB}, 0);
    join
  endtask

  task end_of_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge CLOCK);
    #2 SRST = 1'b0;
    repeat (2) @(posedge CLOCK);
    #2;
    sc_unsigned;
    sc_signed;
    sc_dual;
    sc_fill;
    sc_reset;
    end_of_test;
  end
endmodule // tb_top

bind srtbd_top srtbd_props #(.FIFO_DEPTH(FIFO_DEPTH)) props_u (.CLOCK(CLOCK), .SRST(SRST),
  .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY), .BYTE_DATA(BYTE_DATA), .FORMAT(FORMAT),
  .TEXEL_VALID(TEXEL_VALID), .TEXEL_READY(TEXEL_READY), .TEXEL_VALUE(TEXEL_VALUE),
  .TEXEL_WIDE(TEXEL_WIDE), .TEXEL_PIXEL(TEXEL_PIXEL), .TEXEL_CHANNEL(TEXEL_CHANNEL),
  .TEXEL_LAST(TEXEL_LAST));
